//--- mcu4_core.sv
// Purpose: Instruction decode and execute for a 4-bit controller
// Assumes: rom_data answers rom_addr within the same cycle; inputs synchronous
// Notes: One instruction cycle per mclk edge while ce and the run bit are high
// Operation
// - carry_sum_skip adds A, C, RAM; skips on carry
// - immediate_sum_skip adds immediate, skips on carry
// - inverted_sum_skip adds complement A, RAM, C
// - Plain accumulator operations never skip, keep carry
// - indirect_jump loads low eight counter bits from ROM
// - jump_in_page replaces low six counter bits, seven in pages 2-3
// - page_two_call pushes, jumps into page two, or page ten when the next address has bit 9 set
// - subroutine_exit pops stack; exit_and_skip also skips
// - direct_load and direct_swap use explicit RAM address
// - store_immediate_bump writes immediate, increments digit_pointer
// - swap_decrement swaps, decrements, skips past zero
// - swap_increment swaps, increments, skips past fifteen
// - pointer_load_immediate single byte or prefixed form
// - Consecutive pointer_load_immediate after first are skipped
// - function_latch_load copies immediate into function latch
// - Bit tests skip when RAM or port bit zero
// - timer_overflow_skip skips on overflow, clears it
// - latch_input_read packs latches and clock pin into A
// - l_port_read splits port into RAM and A
// - digit_to_output_port copies digit_pointer to the D output port
// - serial_swap swaps A and register, carry to gate
// - Skipped instruction spends one cycle per byte
// - indirect_jump and table load take two cycles
// - Ten-bit time base divides by 1024, latches overflow
// - latch_input_read clears the falling_edge_latches
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns
module mcu4_core #(
    parameter int TB_WIDTH = mcu4_pkg::TB_BITS
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire mcu4_pkg::reg_req_t bus_req,
    output logic [31:0] rdata,
    input wire logic [7:0] rom_data,
    output logic [9:0] rom_addr,
    input wire logic [3:0] in_pins,
    input wire logic cko_in,
    input wire logic [3:0] g_in,
    input wire logic [7:0] l_in,
    output logic [3:0] d_out,
    output logic [3:0] g_out,
    output logic [7:0] q_out,
    output logic [3:0] en_out,
    output logic sk_out
);
    import mcu4_pkg::*;

    core_t r_ff;
    core_t nxt_r;
    logic [TB_WIDTH-1:0] tb_ff;
    logic [TB_WIDTH-1:0] nxt_tb;
    logic go;
    logic ex1;
    logic [3:0] m;

    // Bit set/reset decode: {valid, set, bit}
    function automatic logic [3:0] bit_op(input logic [7:0] op);
        case (op)
            8'h4c: bit_op = 4'b1000;
            8'h45: bit_op = 4'b1001;
            8'h42: bit_op = 4'b1010;
            8'h43: bit_op = 4'b1011;
            8'h4d: bit_op = 4'b1100;
            8'h47: bit_op = 4'b1101;
            8'h46: bit_op = 4'b1110;
            8'h4b: bit_op = 4'b1111;
            default: bit_op = 4'b0000;
        endcase
    endfunction

    // Bit index of the test encodings 01/11/03/13
    function automatic logic [1:0] test_bit(input logic [7:0] op);
        test_bit = {op[1], op[4]};
    endfunction

    assign go = ce && r_ff.run;
    // Reset edge excluded, the core does not execute the byte seen there
    assign ex1 = go && !srst && r_ff.st == S_FETCH && !r_ff.skip;
    assign m = r_ff.ram[r_ff.b];

    // Next-state logic for the whole core
    always_comb begin
        logic [9:0] p1;
        logic [4:0] sum;
        logic [5:0] waddr;
        logic [3:0] wval;
        logic we;
        logic [7:0] op;
        logic [7:0] b2;
        logic [3:0] bo;
        logic is_lbi;
        logic il_clr;
        p1 = r_ff.pc + 10'h001;
        sum = 5'h00;
        waddr = r_ff.b;
        wval = 4'h0;
        we = 1'b0;
        op = rom_data;
        b2 = rom_data;
        bo = bit_op(rom_data);
        is_lbi = rom_data[7:6] == 2'b00 && rom_data[3];
        il_clr = 1'b0;
        nxt_r = r_ff;
        nxt_tb = tb_ff;
        if (ce) begin
            // Read data stands only in the enabled cycle after the strobe
            nxt_r.rdata = 32'h0000_0000;
            if (bus_req.rd && bus_req.addr == CTRL_OFS) begin
                nxt_r.rdata[CTRL_RUN_POS] = r_ff.run;
            end else if (bus_req.rd && bus_req.addr == STAT_OFS) begin
                nxt_r.rdata[STAT_SKIP_POS] = r_ff.skip;
                nxt_r.rdata[STAT_C_POS] = r_ff.c;
                nxt_r.rdata[STAT_A_POS +: 4] = r_ff.a;
                nxt_r.rdata[STAT_B_POS +: 6] = r_ff.b;
                nxt_r.rdata[STAT_PC_POS +: 10] = r_ff.pc;
            end
            if (bus_req.wr && bus_req.addr == CTRL_OFS) begin
                nxt_r.run = bus_req.wdata[CTRL_RUN_POS];
            end
        end
        if (go) begin
            // Time base runs every instruction cycle
            nxt_tb = tb_ff + 1'b1;
            nxt_r.inp = {in_pins[3], in_pins[0]};
            case (r_ff.st)
                S_FETCH: begin
                    nxt_r.pc = p1;
                    nxt_r.rom_addr = p1;
                    nxt_r.op = op;
                    nxt_r.skip = 1'b0;
                    if (op == OP_PFX || op == OP_LDD || op[7:4] == 4'h6) begin
                        // Second byte is fetched even when skipped
                        nxt_r.st = S_SECOND;
                        nxt_r.sk2 = r_ff.skip;
                    end else if (r_ff.skip || (r_ff.pointer_load_immediate && is_lbi)) begin
                        nxt_r.pointer_load_immediate = r_ff.pointer_load_immediate && is_lbi;
                    end else begin
                        nxt_r.pointer_load_immediate = is_lbi;
                        case (op)
                            OP_CLRA: nxt_r.a = 4'h0;
                            OP_XOR: nxt_r.a = r_ff.a ^ m;
                            OP_COMP: nxt_r.a = ~r_ff.a;
                            OP_ADD: nxt_r.a = r_ff.a + m;
                            OP_ADT: nxt_r.a = r_ff.a + ADT_TEN;
                            OP_ASC, OP_INVERTED_SUM_SKIP: begin
                                sum = {1'b0, op == OP_INVERTED_SUM_SKIP ? ~r_ff.a : r_ff.a} + {1'b0, m} + {4'h0, r_ff.c};
                                nxt_r.a = sum[3:0];
                                nxt_r.c = sum[4];
                                nxt_r.skip = sum[4];
                            end
                            OP_XABR: begin
                                nxt_r.a = {2'b00, r_ff.b[5:4]};
                                nxt_r.b[5:4] = r_ff.a[1:0];
                            end
                            OP_SKC: nxt_r.skip = r_ff.c;
                            OP_SKE: nxt_r.skip = r_ff.a == m;
                            OP_SC: nxt_r.c = 1'b1;
                            OP_RC: nxt_r.c = 1'b0;
                            OP_SKT: begin
                                nxt_r.skip = r_ff.tovf;
                                nxt_r.tovf = 1'b0;
                            end
                            OP_RET, OP_EXIT_AND_SKIP: begin
                                nxt_r.pc = r_ff.sa;
                                nxt_r.rom_addr = r_ff.sa;
                                nxt_r.sa = r_ff.sb;
                                nxt_r.sb = r_ff.sc;
                                nxt_r.skip = op == OP_EXIT_AND_SKIP;
                            end
                            OP_CBA: nxt_r.a = r_ff.b[3:0];
                            OP_CAB: nxt_r.b[3:0] = r_ff.a;
                            OP_XAS: begin
                                nxt_r.a = r_ff.serial_shift_counter;
                                nxt_r.serial_shift_counter = r_ff.a;
                                nxt_r.clock_gate_latch = r_ff.c;
                            end
                            OP_JID, OP_TABLE_LOAD_TO_OUTPUT_LATCH: begin
                                // Page bits come from the incremented counter
                                nxt_r.rom_addr = {p1[9:8], r_ff.a, m};
                                nxt_r.st = S_IND;
                                if (op == OP_TABLE_LOAD_TO_OUTPUT_LATCH) begin
                                    nxt_r.sc = r_ff.sb;
                                end
                            end
                            default: begin
                                if (is_lbi) begin
                                    nxt_r.b = {op[5:4], op[3:0] + 4'h1};
                                end else if (op[7:6] == 2'b00 && op[3:2] == 2'b01) begin
                                    nxt_r.a = m;
                                    nxt_r.b[5:4] = r_ff.b[5:4] ^ op[5:4];
                                    if (op[1:0] != 2'b01) begin
                                        we = 1'b1;
                                        wval = r_ff.a;
                                    end
                                    if (op[1:0] == 2'b11) begin
                                        nxt_r.b[3:0] = r_ff.b[3:0] - 4'h1;
                                        nxt_r.skip = r_ff.b[3:0] == 4'h0;
                                    end else if (op[1:0] == 2'b00) begin
                                        nxt_r.b[3:0] = r_ff.b[3:0] + 4'h1;
                                        nxt_r.skip = r_ff.b[3:0] == 4'hf;
                                    end
                                end else if (op[7:5] == 3'b000 && op[3:2] == 2'b00 && op[0]) begin
                                    nxt_r.skip = !m[test_bit(op)];
                                end else if (op[7:4] == 4'h5) begin
                                    sum = {1'b0, r_ff.a} + {1'b0, op[3:0]};
                                    nxt_r.a = sum[3:0];
                                    nxt_r.skip = sum[4];
                                end else if (op[7:4] == 4'h7) begin
                                    we = 1'b1;
                                    wval = op[3:0];
                                    nxt_r.b[3:0] = r_ff.b[3:0] + 4'h1;
                                end else if (bo[3]) begin
                                    we = 1'b1;
                                    wval = m;
                                    wval[bo[1:0]] = bo[2];
                                end else if (op[7] && p1[9:7] == PAGE23) begin
                                    nxt_r.pc[6:0] = op[6:0];
                                    nxt_r.rom_addr = {p1[9:7], op[6:0]};
                                end else if (op[7:6] == 2'b11) begin
                                    nxt_r.pc[5:0] = op[5:0];
                                    nxt_r.rom_addr = {p1[9:6], op[5:0]};
                                end else if (op[7:6] == 2'b10) begin
                                    nxt_r.sa = p1;
                                    nxt_r.sb = r_ff.sa;
                                    nxt_r.sc = r_ff.sb;
                                    nxt_r.pc = {p1[9], 1'b0, PAGE_TWO_CALL_PAGE_HI, op[5:0]};
                                    nxt_r.rom_addr = {p1[9], 1'b0, PAGE_TWO_CALL_PAGE_HI, op[5:0]};
                                end
                            end
                        endcase
                    end
                end
                S_SECOND: begin
                    nxt_r.st = S_FETCH;
                    nxt_r.pc = p1;
                    nxt_r.rom_addr = p1;
                    if (r_ff.sk2 || (r_ff.pointer_load_immediate && r_ff.op == OP_PFX && b2[7:6] == 2'b10)) begin
                        nxt_r.pointer_load_immediate = r_ff.pointer_load_immediate && r_ff.op == OP_PFX && b2[7:6] == 2'b10;
                    end else if (r_ff.op == OP_LDD) begin
                        nxt_r.pointer_load_immediate = 1'b0;
                        nxt_r.a = r_ff.ram[b2[5:0]];
                        if (b2[7]) begin
                            we = 1'b1;
                            waddr = b2[5:0];
                            wval = r_ff.a;
                        end
                    end else if (r_ff.op[7:4] == 4'h6) begin
                        nxt_r.pointer_load_immediate = 1'b0;
                        nxt_r.pc = {r_ff.op[1:0], b2};
                        nxt_r.rom_addr = {r_ff.op[1:0], b2};
                        if (r_ff.op[3]) begin
                            nxt_r.sa = p1;
                            nxt_r.sb = r_ff.sa;
                            nxt_r.sc = r_ff.sb;
                        end
                    end else begin
                        nxt_r.pointer_load_immediate = b2[7:6] == 2'b10;
                        case (b2)
                            P2_CAMQ: nxt_r.q = {r_ff.a, m};
                            P2_CQMA: begin
                                we = 1'b1;
                                wval = r_ff.q[7:4];
                                nxt_r.a = r_ff.q[3:0];
                            end
                            P2_SKGZ: nxt_r.skip = g_in == 4'h0;
                            P2_ING: nxt_r.a = g_in;
                            P2_ININ: nxt_r.a = in_pins;
                            P2_LATCH_INPUT_READ: begin
                                nxt_r.a = {r_ff.il[1], cko_in, 1'b0, r_ff.il[0]};
                                il_clr = 1'b1;
                            end
                            P2_INL: begin
                                we = 1'b1;
                                wval = l_in[7:4];
                                nxt_r.a = l_in[3:0];
                            end
                            P2_OBD: nxt_r.d = r_ff.b[3:0];
                            P2_OMC: nxt_r.g = m;
                            default: begin
                                if (b2[7:4] == 4'h6) begin
                                    nxt_r.en = b2[3:0];
                                end else if (b2[7:4] == 4'h5) begin
                                    nxt_r.g = b2[3:0];
                                end else if (b2[7:6] == 2'b10) begin
                                    nxt_r.b = b2[5:0];
                                end else if (b2[7:5] == 3'b000 && b2[3:2] == 2'b00 && b2[0]) begin
                                    nxt_r.skip = !g_in[test_bit(b2)];
                                end
                            end
                        endcase
                    end
                end
                S_IND: begin
                    nxt_r.st = S_FETCH;
                    if (r_ff.op == OP_JID) begin
                        nxt_r.pc = {r_ff.pc[9:8], rom_data};
                        nxt_r.rom_addr = {r_ff.pc[9:8], rom_data};
                    end else begin
                        nxt_r.q = rom_data;
                        nxt_r.rom_addr = r_ff.pc;
                    end
                end
                default: nxt_r.st = S_FETCH;
            endcase
            if (we) begin
                nxt_r.ram[waddr] = wval;
            end
            // Event sets win over the instruction clears
            if (&tb_ff) begin
                nxt_r.tovf = 1'b1;
            end
            nxt_r.il = (il_clr ? 2'b00 : r_ff.il) | (r_ff.inp & ~{in_pins[3], in_pins[0]});
        end
        // RAM keeps its contents across reset
        if (srst) begin
            nxt_r = '0;
            nxt_r.ram = r_ff.ram;
            nxt_r.st = S_FETCH;
            nxt_r.pc = PC_RST;
            nxt_r.rom_addr = PC_RST;
            nxt_r.run = CTRL_RUN_RST;
            nxt_r.inp = 2'b11;
            nxt_tb = '0;
        end
    end

    // State register and time base register
    always_ff @(posedge mclk) begin
        r_ff <= nxt_r;
        tb_ff <= nxt_tb;
    end

    assign rdata = r_ff.rdata;
    assign rom_addr = r_ff.rom_addr;
    assign d_out = r_ff.d;
    assign g_out = r_ff.g;
    assign q_out = r_ff.q;
    assign en_out = r_ff.en;
    assign sk_out = r_ff.clock_gate_latch;

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_exec(logic [7:0] code);
        ex1 && rom_data == code;
    endsequence

    property p_asc;
        s_exec(OP_ASC) |=> r_ff.c == r_ff.skip && r_ff.a == 4'($past(r_ff.a) + $past(m) + $past(r_ff.c));
    endproperty
    a_asc: assert property (p_asc) else $error("carry sum wrong");

    property p_immediate_sum_skip;
        ex1 && rom_data[7:4] == 4'h5 && rom_data[3:0] != 4'h0 |=>
            r_ff.a == 4'($past(r_ff.a) + $past(rom_data[3:0])) &&
            r_ff.skip == ({1'b0, $past(r_ff.a)} + {1'b0, $past(rom_data[3:0])} > 5'h0f);
    endproperty
    a_immediate_sum_skip: assert property (p_immediate_sum_skip) else $error("immediate sum wrong");

    property p_plain;
        (s_exec(OP_ADD) or s_exec(OP_ADT) or s_exec(OP_COMP)) |=> !r_ff.skip && r_ff.c == $past(r_ff.c);
    endproperty
    a_plain: assert property (p_plain) else $error("plain op skipped or hit carry");

    property p_ind_two;
        s_exec(OP_JID) |=> r_ff.st == S_IND ##1 (r_ff.st == S_IND || r_ff.st == S_FETCH);
    endproperty
    a_ind_two: assert property (p_ind_two) else $error("indirect jump not two cycles");

    property p_ret;
        s_exec(OP_RET) |=> r_ff.pc == $past(r_ff.sa) && r_ff.sa == $past(r_ff.sb) && !r_ff.skip;
    endproperty
    a_ret: assert property (p_ret) else $error("return pop wrong");

    property p_skt;
        s_exec(OP_SKT) && r_ff.tovf && !(&tb_ff) |=> r_ff.skip && !r_ff.tovf;
    endproperty
    a_skt: assert property (p_skt) else $error("timer skip wrong");

    property p_tb_wrap;
        go && (&tb_ff) |=> r_ff.tovf && tb_ff == '0;
    endproperty
    a_tb_wrap: assert property (p_tb_wrap) else $error("time base overflow lost");

    property p_xas;
        s_exec(OP_XAS) |=> r_ff.clock_gate_latch == $past(r_ff.c) && r_ff.serial_shift_counter == $past(r_ff.a) && r_ff.a == $past(r_ff.serial_shift_counter);
    endproperty
    a_xas: assert property (p_xas) else $error("serial swap wrong");

    property p_skipped;
        go && r_ff.st == S_FETCH && r_ff.skip && rom_data[7:4] != 4'h6 && rom_data != OP_PFX &&
            rom_data != OP_LDD |=> r_ff.st == S_FETCH && r_ff.a == $past(r_ff.a) && !r_ff.skip;
    endproperty
    a_skipped: assert property (p_skipped) else $error("skipped byte executed");
endmodule

//--- mcu4_pkg.sv
// Purpose: Shared constants and carrier types for the 4-bit controller core
// Assumes: One instruction cycle per enabled mclk edge
// Notes: Register offsets are byte addresses on the plain register port
package mcu4_pkg;
    // Register port map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam int CTRL_RUN_POS = 0;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam int STAT_SKIP_POS = 0;
    localparam int STAT_C_POS = 1;
    localparam int STAT_A_POS = 4;
    localparam int STAT_B_POS = 8;
    localparam int STAT_PC_POS = 16;
    // Sizes and reset values
    localparam int TB_BITS = 10;
    localparam logic [9:0] PC_RST = 10'h000;
    localparam logic [3:0] ADT_TEN = 4'ha;
    localparam logic [1:0] PAGE_TWO_CALL_PAGE_HI = 2'b10;
    localparam logic [2:0] PAGE23 = 3'b001;
    // First-byte opcodes; LDD and PFX take a second byte
    localparam logic [7:0] OP_CLRA = 8'h00, OP_XOR = 8'h02, OP_INVERTED_SUM_SKIP = 8'h10, OP_XABR = 8'h12;
    localparam logic [7:0] OP_SKC = 8'h20, OP_SKE = 8'h21, OP_SC = 8'h22, OP_LDD = 8'h23;
    localparam logic [7:0] OP_ASC = 8'h30, OP_ADD = 8'h31, OP_RC = 8'h32, OP_PFX = 8'h33;
    localparam logic [7:0] OP_COMP = 8'h40, OP_SKT = 8'h41, OP_RET = 8'h48, OP_EXIT_AND_SKIP = 8'h49;
    localparam logic [7:0] OP_ADT = 8'h4a, OP_CBA = 8'h4e, OP_XAS = 8'h4f, OP_CAB = 8'h50;
    localparam logic [7:0] OP_TABLE_LOAD_TO_OUTPUT_LATCH = 8'hbf, OP_JID = 8'hff;
    // Second bytes after the prefix
    localparam logic [7:0] P2_SKGZ = 8'h21, P2_ININ = 8'h28, P2_LATCH_INPUT_READ = 8'h29, P2_ING = 8'h2a;
    localparam logic [7:0] P2_CQMA = 8'h2c, P2_INL = 8'h2e, P2_OMC = 8'h3a, P2_CAMQ = 8'h3c;
    localparam logic [7:0] P2_OBD = 8'h3e;
    typedef enum logic [2:0] {
        S_FETCH = 3'b001,
        S_SECOND = 3'b010,
        S_IND = 3'b100
    } state_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        state_t st;
        logic [9:0] pc;
        logic [9:0] rom_addr;
        logic [3:0] a;
        logic c;
        logic [5:0] b;
        logic [9:0] sa;
        logic [9:0] sb;
        logic [9:0] sc;
        logic [7:0] op;
        logic [7:0] q;
        logic [3:0] d;
        logic [3:0] g;
        logic [3:0] en;
        logic [3:0] serial_shift_counter;
        logic clock_gate_latch;
        logic skip;
        logic sk2;
        logic pointer_load_immediate;
        logic tovf;
        logic [9:0] tb;
        logic [1:0] il;
        logic [1:0] inp;
        logic run;
        logic [31:0] rdata;
        logic [63:0][3:0] ram;
    } core_t;
endpackage

//--- code_rom.sv
// Purpose: Program store that hands instruction bytes to the core
// Assumes: The core samples the byte in the same cycle as the address
// Notes: The bench fills words; blank words act as clear, so runaway code never settles
`timescale 1ns/1ns
module code_rom (
    input wire logic [9:0] addr,
    output logic [7:0] data
);
    logic [7:0] mem [1024];
    // Combinational answer, no wait states
    assign data = mem[addr];
endmodule

//--- test_four_bit_mcu_instruction_decoder.sv
// Purpose: Self-checking bench for the 4-bit controller core
// Assumes: Every program ends in a jump to itself so the fetch address settles
// Notes: State is read back through the status register after each program
`timescale 1ns/1ns
module test_four_bit_mcu_instruction_decoder;
    import mcu4_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    reg_req_t bus_req = '0;
    logic [31:0] rdata;
    logic [7:0] rom_data;
    logic [9:0] rom_addr;
    logic [3:0] in_pins = 4'hf;
    logic cko_in = 1'b0;
    logic [3:0] g_in = 4'h0;
    logic [7:0] l_in = 8'h00;
    logic [3:0] d_out;
    logic [3:0] en_out;
    logic [7:0] q_out;
    logic sk_out;
    int num_errors = 0;
    int total_checks = 0;
    int y1, y2, y3, s;
    logic [31:0] st;
    always #25 mclk = ~mclk;
    // Pin inputs wander at random; no program here depends on them
    always @(posedge mclk) begin
        in_pins <= 4'($urandom);
        cko_in <= 1'($urandom);
        g_in <= 4'($urandom);
        l_in <= 8'($urandom);
    end
    mcu4_core #(.TB_WIDTH(4)) uut (.mclk(mclk), .srst(srst), .ce(ce), .bus_req(bus_req), .rdata(rdata),
        .rom_data(rom_data), .rom_addr(rom_addr), .in_pins(in_pins), .cko_in(cko_in), .g_in(g_in),
        .l_in(l_in), .d_out(d_out), .g_out(), .q_out(q_out), .en_out(en_out), .sk_out(sk_out));
    code_rom rom (.addr(rom_addr), .data(rom_data));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        total_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("[FAIL] t=%0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask
    task automatic bus_read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge mclk);
        bus_req.addr <= addr;
        bus_req.rd <= 1'b1;
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 data = rdata;
    endtask
    // Reload low ROM under reset, run until the fetch address stops, then read status
    task automatic run_prog(input string name, input logic [7:0] prog [$]);
        logic [9:0] last;
        int n;
        @(posedge mclk);
        srst <= 1'b1;
        // Load only while reset is seen, so the old program never runs a changed byte
        @(posedge mclk);
        foreach (prog[i]) rom.mem[i] <= prog[i];
        @(posedge mclk);
        srst <= 1'b0;
        last = 10'h3ff;
        for (n = 0; n < 200; n++) begin
            @(posedge mclk);
            #1;
            if (rom_addr === last) break;
            last = rom_addr;
        end
        if (n == 200) begin
            check(32'(rom_addr), 32'(last), "fetch never settled");
            wrap_up();
        end
        bus_read(STAT_OFS, st);
        $display("test %s done", name);
    endtask
    // Sum, decimal adjust when no carry, then immediate add with the same adjust
    function automatic logic [31:0] exp_acc(input int s, input int y);
        int a;
        a = (s > 15) ? s % 16 : (s + 10) % 16;
        a = a + y;
        return (a > 15) ? 32'(a % 16) : 32'((a + 10) % 16);
    endfunction
    initial begin
        void'($urandom(54));
        foreach (rom.mem[i]) rom.mem[i] = 8'h00;
        rom.mem[10'h081] = 8'h53;
        rom.mem[10'h082] = 8'h49;
        rom.mem[10'h0d5] = 8'he0;
        rom.mem[10'h0e0] = 8'h52;
        rom.mem[10'h0e1] = 8'he1;
        rom.mem[10'h090] = 8'h48;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        bus_read(CTRL_OFS, st);
        check(32'(st[CTRL_RUN_POS]), 32'(CTRL_RUN_RST), "run bit after reset");
        bus_read(8'h08, st);
        check(st, 32'h0, "unmapped read");
        // Random operands, with y1 and y2 forced to all ones in the last pass; y3 stays random
        for (int k = 0; k < 5; k++) begin
            y1 = (k == 4) ? 15 : $urandom_range(15);
            y2 = (k == 4) ? 15 : $urandom_range(15, 1);
            y3 = $urandom_range(15, 1);
            run_prog("sums", '{8'h00, 8'h0f, 8'h70 | 8'(y1), 8'h0f, 8'h50 | 8'(y2), 8'h22, 8'h30, 8'h4a,
                8'h50 | 8'(y3), 8'h4a, 8'hca});
            s = y1 + y2 + 1;
            check(32'(st[7:4]), exp_acc(s, y3), "accumulator after sums");
            check(32'(st[STAT_C_POS]), 32'(s > 15), "carry after sums");
        end
        run_prog("complement", '{8'h00, 8'h22, 8'h40, 8'hc3});
        check({28'h0, st[7:4]}, 32'hf, "complement");
        check(32'(st[STAT_C_POS]), 32'h1, "carry kept");
        // RAM is never cleared, so the swapped word is stored first
        run_prog("store and increment", '{8'h00, 8'h0e, 8'h73, 8'h0e, 8'h04, 8'h3f, 8'hc6});
        check(32'(st[13:8]), 32'h00, "pointer after wrap skip");
        check(32'(st[7:4]), 32'h3, "swap increment data");
        run_prog("pointer chain", '{8'h00, 8'h2f, 8'h1f, 8'h3f, 8'hc4});
        check(32'(st[13:8]), 32'h20, "pointer chain");
        run_prog("indirect", '{8'h00, 8'h0f, 8'h75, 8'h0f, 8'h5d, 8'hff});
        check(32'(st[7:4]), 32'hf, "indirect target");
        run_prog("call and return", '{8'h00, 8'h81, 8'h54, 8'hc3});
        check(32'(st[7:4]), 32'h3, "return skips");
        y1 = $urandom_range(15);
        y2 = $urandom_range(15);
        // Two serial swaps inside three cycles, call and plain exit, timer wait, output latches
        run_prog("io", '{8'h00, 8'h50 | 8'(y3), 8'h4f, 8'h22, 8'h4f, 8'h90, 8'h41, 8'hc6, 8'h0c,
            8'h70 | 8'(y1), 8'h33, 8'h3e, 8'h0c, 8'h33, 8'h3c, 8'h33, 8'h60 | 8'(y2), 8'hd1});
        check(32'(st[7:4]), 32'(y3), "serial swap return");
        check(32'(sk_out), 32'h1, "clock gate from carry");
        check(32'(d_out), 32'he, "digit to output");
        check(32'(q_out), 32'({4'(y3), 4'(y1)}), "output latch from A and RAM");
        check(32'(en_out), 32'(y2), "function latch");
        check(32'(st[STAT_PC_POS +: 10]), 32'h11, "call, timer wait, jump");
        wrap_up();
    end
endmodule
